/* File: hw/tws_top.sv */
// Purpose: two-wire slave transmitter with apb register access
// Assumes: scl and sda are open drain, pins asynchronous to pclk
// Notes: apb answers with pready in the first access cycle
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module tws_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sleep_mode,
    output logic scl_o,
    output logic scl_oe,
    output logic sda_o,
    output logic sda_oe,
    output logic wake_req
);
    ////////////////////////////////////////////////////////////////////
    function automatic logic addr_match(input logic [7:0] b,
                                        input logic [7:0] own);
        addr_match = (b[7:1] == own[7:1])
            || ((b == tws_pkg::GC_ADDR) && own[tws_pkg::AB_GCE]);
    endfunction

    tws_line_if line ();
    tws_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .line(line)
    );

    tws_pkg::tws_state_e st_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] own_reg;
    logic [7:0] data_reg;
    logic [1:0] presc_reg;
    logic [7:0] status_reg;
    logic [7:0] shift_reg;
    logic [3:0] cnt_reg;
    logic tx_mode_reg;
    logic last_reg;
    logic ack_reg;
    logic arb_reg;
    logic free_reg;
    logic pend_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic scl_oe_reg;
    logic sda_oe_reg;
    logic wake_reg;

    ////////////////////////////////////////////////////////////////////
    // apb decode
    logic setup;
    logic wr_en;
    logic sel_ctrl;
    logic sel_stat;
    logic sel_data;
    logic sel_addr;
    logic mapped;
    logic jd;
    logic ea;
    logic en;
    logic jd_clr;
    logic [7:0] stat_rd;
    logic [7:0] rd_byte;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && pready_reg;
    assign sel_ctrl = paddr == tws_pkg::OFS_CTRL;
    assign sel_stat = paddr == tws_pkg::OFS_STAT;
    assign sel_data = paddr == tws_pkg::OFS_DATA;
    assign sel_addr = paddr == tws_pkg::OFS_ADDR;
    assign mapped = sel_ctrl || sel_stat || sel_data || sel_addr;
    assign jd = ctrl_reg[tws_pkg::CB_JD];
    assign ea = ctrl_reg[tws_pkg::CB_EA];
    assign en = ctrl_reg[tws_pkg::CB_EN];
    assign jd_clr = wr_en && sel_ctrl && pwdata[tws_pkg::CB_JD];
    // code bits only, prescaler positions carry the stored field
    assign stat_rd = {(jd ? status_reg[7:3] : tws_pkg::ST_NONE[7:3]),
                      1'b0, presc_reg};
    assign rd_byte = sel_ctrl ? ctrl_reg
                   : sel_stat ? stat_rd
                   : sel_data ? data_reg
                   : sel_addr ? own_reg : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup && !mapped;
            if (setup && !pwrite) begin
                prdata_reg <= {24'h00_0000, rd_byte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus-side events and next status
    logic jd_set;
    logic hit;
    logic tmr_go;
    logic tmr_done;
    logic [7:0] st_next;
    logic [7:0] aack_code;
    logic [7:0] wr_code;
    logic [7:0] dack_code;

    assign hit = en && ea && addr_match(shift_reg, own_reg);
    assign wr_code = (shift_reg == tws_pkg::GC_ADDR)
        ? (arb_reg ? tws_pkg::ST_GC_AL : tws_pkg::ST_GC)
        : (arb_reg ? tws_pkg::ST_SRW_AL : tws_pkg::ST_SRW);
    assign aack_code = tx_mode_reg
        ? (arb_reg ? tws_pkg::ST_SR_AL : tws_pkg::ST_SR_ACK)
        : wr_code;
    assign dack_code = !ack_reg ? tws_pkg::ST_TX_NACK
        : (last_reg ? tws_pkg::ST_TX_LAST : tws_pkg::ST_TX_ACK);
    assign jd_set = line.scl_fall && !line.start_det && !line.stop_det
        && ((st_reg == tws_pkg::S_AACK) || (st_reg == tws_pkg::S_DACK))
        || tmr_done;
    assign st_next = tmr_done ? tws_pkg::ST_MSTART
        : (st_reg == tws_pkg::S_AACK) ? aack_code : dack_code;
    assign tmr_go = (st_reg == tws_pkg::S_IDLE) && pend_reg && free_reg
        && en && !line.start_det && !line.stop_det;

    tws_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(tmr_go),
        .done(tmr_done)
    );

    ////////////////////////////////////////////////////////////////////
    // registers: set of job done wins over its clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= tws_pkg::CTRL_RST;
            own_reg <= tws_pkg::ADDR_RST;
            data_reg <= tws_pkg::DATA_RST;
            presc_reg <= 2'h0;
            status_reg <= tws_pkg::ST_NONE;
        end else begin
            if (wr_en && sel_ctrl) begin
                ctrl_reg[tws_pkg::CB_EA] <= pwdata[tws_pkg::CB_EA];
                ctrl_reg[tws_pkg::CB_STA] <= pwdata[tws_pkg::CB_STA];
                ctrl_reg[tws_pkg::CB_STO] <= pwdata[tws_pkg::CB_STO];
                ctrl_reg[tws_pkg::CB_EN] <= pwdata[tws_pkg::CB_EN];
                ctrl_reg[tws_pkg::CB_IE] <= pwdata[tws_pkg::CB_IE];
            end
            if (wr_en && sel_addr) begin
                own_reg <= pwdata[7:0];
            end
            if (wr_en && sel_stat) begin
                presc_reg <= pwdata[1:0];
            end
            if (wr_en && sel_data && jd) begin
                data_reg <= pwdata[7:0];
            end
            if (wr_en && sel_data) begin
                ctrl_reg[tws_pkg::CB_WC] <= !jd;
            end
            if (jd_set) begin
                ctrl_reg[tws_pkg::CB_JD] <= 1'b1;
                status_reg <= st_next;
            end else if (jd_clr) begin
                ctrl_reg[tws_pkg::CB_JD] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= tws_pkg::S_IDLE;
            shift_reg <= 8'h00;
            cnt_reg <= 4'h0;
            tx_mode_reg <= 1'b0;
            last_reg <= 1'b0;
            ack_reg <= 1'b0;
            arb_reg <= 1'b0;
            free_reg <= 1'b1;
            pend_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else if (!en) begin
            st_reg <= tws_pkg::S_IDLE;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            pend_reg <= 1'b0;
        end else if (line.stop_det) begin
            st_reg <= tws_pkg::S_IDLE;
            sda_oe_reg <= 1'b0;
            free_reg <= 1'b1;
        end else if (line.start_det && st_reg != tws_pkg::S_START) begin
            // own bus attempt lost to another master's start
            arb_reg <= pend_reg && (st_reg == tws_pkg::S_IDLE);
            st_reg <= tws_pkg::S_ADDR;
            cnt_reg <= 4'h0;
            free_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else begin
            case (st_reg)
                tws_pkg::S_IDLE: begin
                    if (tmr_go) begin
                        sda_oe_reg <= 1'b1;
                        st_reg <= tws_pkg::S_START;
                    end
                end
                tws_pkg::S_START: begin
                    if (tmr_done) begin
                        scl_oe_reg <= 1'b1;
                        pend_reg <= 1'b0;
                        tx_mode_reg <= 1'b0;
                        st_reg <= tws_pkg::S_WAIT;
                    end
                end
                tws_pkg::S_ADDR: begin
                    if (line.scl_rise) begin
                        shift_reg <= {shift_reg[6:0], line.sda};
                        cnt_reg <= cnt_reg + 4'h1;
                    end else if (line.scl_fall
                                 && cnt_reg == tws_pkg::BYTE_BITS) begin
                        if (hit) begin
                            sda_oe_reg <= 1'b1;
                            tx_mode_reg <= shift_reg[0];
                            st_reg <= tws_pkg::S_AACK;
                        end else begin
                            st_reg <= tws_pkg::S_IGNORE;
                        end
                    end
                end
                tws_pkg::S_AACK: begin
                    if (line.scl_fall) begin
                        sda_oe_reg <= 1'b0;
                        scl_oe_reg <= 1'b1;
                        st_reg <= tws_pkg::S_WAIT;
                    end
                end
                tws_pkg::S_WAIT: begin
                    if (!jd) begin
                        scl_oe_reg <= 1'b0;
                        if (tx_mode_reg) begin
                            shift_reg <= data_reg;
                            sda_oe_reg <= !data_reg[7];
                            cnt_reg <= 4'h1;
                            st_reg <= tws_pkg::S_TX;
                        end else begin
                            sda_oe_reg <= 1'b0;
                            pend_reg <= ctrl_reg[tws_pkg::CB_STA];
                            st_reg <= tws_pkg::S_IDLE;
                        end
                    end
                end
                tws_pkg::S_TX: begin
                    if (line.scl_fall) begin
                        if (cnt_reg == tws_pkg::BYTE_BITS) begin
                            sda_oe_reg <= 1'b0;
                            last_reg <= !ea;
                            st_reg <= tws_pkg::S_DACK;
                        end else begin
                            sda_oe_reg <= !shift_reg[6];
                            shift_reg <= {shift_reg[6:0], 1'b1};
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    end
                end
                tws_pkg::S_DACK: begin
                    if (line.scl_rise) begin
                        ack_reg <= !line.sda;
                    end else if (line.scl_fall) begin
                        scl_oe_reg <= 1'b1;
                        tx_mode_reg <= ack_reg && !last_reg;
                        st_reg <= tws_pkg::S_WAIT;
                    end
                end
                tws_pkg::S_IGNORE: begin
                    sda_oe_reg <= 1'b0;
                end
                default: begin
                    st_reg <= tws_pkg::S_IDLE;
                end
            endcase
        end
    end

    // wake request from an address match while the core sleeps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= sleep_mode && (wake_reg
                || (jd_set && st_reg == tws_pkg::S_AACK));
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = scl_oe_reg;
    assign sda_oe = sda_oe_reg;
    assign wake_req = wake_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_addr_acked;
        st_reg == tws_pkg::S_AACK && line.scl_fall && !line.start_det
            && !line.stop_det;
    endsequence

    sequence s_start_sent;
        st_reg == tws_pkg::S_START && tmr_done;
    endsequence

    chk_addr_own_match: assert property (
        s_addr_acked |-> addr_match(shift_reg, own_reg) && ea)
        else $error("acked address does not match own address");
    chk_gc_needs_enable: assert property (
        s_addr_acked and shift_reg == tws_pkg::GC_ADDR
            |-> own_reg[tws_pkg::AB_GCE])
        else $error("general call acked while disabled");
    chk_read_mode_a8: assert property (
        s_addr_acked and shift_reg[0] && !arb_reg
            |=> jd && status_reg == tws_pkg::ST_SR_ACK)
        else $error("read address did not report 0xa8");
    chk_arb_lost_b0: assert property (
        s_addr_acked and shift_reg[0] && arb_reg
            |=> status_reg == tws_pkg::ST_SR_AL)
        else $error("lost arbitration read did not report 0xb0");
    chk_ack_status_b8: assert property (
        st_reg == tws_pkg::S_DACK && line.scl_fall && ack_reg && !last_reg
            |=> status_reg == tws_pkg::ST_TX_ACK ##1 jd)
        else $error("ack after byte did not report 0xb8");
    chk_last_ack_c8: assert property (
        st_reg == tws_pkg::S_DACK && line.scl_fall && ack_reg && last_reg
            |=> status_reg == tws_pkg::ST_TX_LAST)
        else $error("ack after last byte did not report 0xc8");
    chk_stretch_scl: assert property (
        jd && st_reg == tws_pkg::S_WAIT |-> scl_oe_reg)
        else $error("scl released while job done is set");
    chk_ignore_release: assert property (
        st_reg == tws_pkg::S_IGNORE |=> !sda_oe_reg || line.start_det)
        else $error("sda driven while ignoring the master");
    chk_presc_zero: assert property (
        status_reg[2:0] == 3'h0)
        else $error("status code has prescaler bits set");
    chk_start_hold: assert property (
        s_start_sent |-> sda_oe_reg ##1 scl_oe_reg && jd)
        else $error("start not held before scl low");
    chk_wake_sleep: assert property (
        $rose(wake_reg) |-> $past(sleep_mode) && jd)
        else $error("wake request outside sleep");
endmodule

/* File: hw/tws_pkg.sv */
// Purpose: constants, register map and states of the two-wire slave
// Assumes: apb with 32-bit data, pclk at 125 MHz
// Notes: status codes are reported with the stored prescaler field in bits 1:0
// Overview of operation
// - Top seven own-address bits form the slave address answered.
// - Own-address bit zero enables answering general call 0x00.
// - Matched address with read bit enters transmit, else receive; here a write address returns to idle once job done is cleared.
// - Acked address plus direction raises job done with valid status.
// - Status codes carry zero in prescaler bit positions.
// - Addressed for read after lost arbitration gives status 0xB0.
// - In 0xA8/0xB0/0xB8 a byte is loaded; ack enable says last.
// - Byte answered ack gives 0xB8, nack gives 0xC0.
// - Ack after the last byte gives status 0xC8.
// - Leaving 0xC0/0xC8 goes not addressed; matching follows ack enable.
// - Start request on leaving 0xC0/0xC8 sends START when bus frees.
// - Ack enable cleared mid-transfer makes current byte the final one.
// - After final byte the master is ignored and SDA stays released.
// - Ack enable low: own address not answered, bus still watched.
// - Asleep, own or general call address still acked, wake requested.
// - After sleep match SCL held low until job done is cleared.
// - Data register need not hold the bus byte after wake-up.
// - While job done is set, SCL low period is stretched.
// - Software clears job done last, as it restarts the interface.
package tws_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_ADDR = 8'h0c;
    localparam int CB_JD = 7;
    localparam int CB_EA = 6;
    localparam int CB_STA = 5;
    localparam int CB_STO = 4;
    localparam int CB_WC = 3;
    localparam int CB_EN = 2;
    localparam int CB_IE = 0;
    localparam int AB_GCE = 0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'hff;
    localparam logic [7:0] GC_ADDR = 8'h00;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [7:0] ST_NONE = 8'hf8;
    localparam logic [7:0] ST_MSTART = 8'h08;
    localparam logic [7:0] ST_SRW = 8'h60;
    localparam logic [7:0] ST_SRW_AL = 8'h68;
    localparam logic [7:0] ST_GC = 8'h70;
    localparam logic [7:0] ST_GC_AL = 8'h78;
    localparam logic [7:0] ST_SR_ACK = 8'ha8;
    localparam logic [7:0] ST_SR_AL = 8'hb0;
    localparam logic [7:0] ST_TX_ACK = 8'hb8;
    localparam logic [7:0] ST_TX_NACK = 8'hc0;
    localparam logic [7:0] ST_TX_LAST = 8'hc8;
    localparam int CLK_NS = 8;
    localparam int T_HD_STA_NS = 4000;
    localparam int HD_STA_CYC = (T_HD_STA_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_AACK, S_TX, S_DACK, S_WAIT, S_IGNORE, S_START
    } tws_state_e;
endpackage

/* File: hw/tws_line_if.sv */
// Purpose: synchronised two-wire line levels and bus events
// Assumes: all signals on pclk
// Notes: events are one-cycle pulses
`timescale 1ns/10ps
interface tws_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    modport src (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
    modport dst (input scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface

/* File: hw/tws_sync.sv */
// Purpose: two-flop synchroniser and edge finder for scl and sda
// Assumes: pins are asynchronous to pclk
// Notes: first stage is read only by the second
`timescale 1ns/10ps
module tws_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic scl_i,
    input wire logic sda_i,
    tws_line_if.src line
);
    logic [1:0] pin_in;
    logic [1:0] meta_reg;
    logic [1:0] sync_reg;
    logic [1:0] prev_reg;

    assign pin_in = {scl_i, sda_i};

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_reg[i] <= 1'b1;
                    sync_reg[i] <= 1'b1;
                    prev_reg[i] <= 1'b1;
                end else begin
                    meta_reg[i] <= pin_in[i];
                    sync_reg[i] <= meta_reg[i];
                    prev_reg[i] <= sync_reg[i];
                end
            end
        end
    endgenerate

    assign line.scl = sync_reg[1];
    assign line.sda = sync_reg[0];
    assign line.scl_rise = sync_reg[1] & ~prev_reg[1];
    assign line.scl_fall = ~sync_reg[1] & prev_reg[1];
    assign line.start_det = sync_reg[1] & prev_reg[1] & ~sync_reg[0]
        & prev_reg[0];
    assign line.stop_det = sync_reg[1] & prev_reg[1] & sync_reg[0]
        & ~prev_reg[0];
endmodule

/* File: hw/tws_timer.sv */
// Purpose: one-shot cycle timer for start hold
// Assumes: start is a one-cycle pulse
// Notes: done pulses once, count cycles after start
`timescale 1ns/10ps
module tws_timer #(
    parameter int COUNT = tws_pkg::HD_STA_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    output logic done
);
    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LAST = W'(COUNT);
    logic [W-1:0] cnt_reg;
    logic run_reg;
    logic at_end;

    assign at_end = run_reg && (cnt_reg == LAST);
    assign done = at_end;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
        end else if (start) begin
            cnt_reg <= W'(1);
            run_reg <= 1'b1;
        end else if (run_reg) begin
            cnt_reg <= cnt_reg + W'(1);
            run_reg <= !at_end;
        end
    end
endmodule

/* File: tb/tws_master_model.sv */
// Purpose: behavioural two-wire bus master receiver
// Assumes: open-drain lines with pull-ups, scl period near 64 ns
// Notes: scl stands high between frames; stretching is waited out
`timescale 1ns/10ps
module tws_master_model (
    input wire logic pclk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_dn,
    output logic sda_dn,
    output logic stuck
);
    initial begin
        scl_dn = 1'b0;
        sda_dn = 1'b0;
        stuck = 1'b0;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // release scl, wait for any stretch to end, then hold high
    task automatic hi();
        int n;
        scl_dn <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (scl !== 1'b1 && n < 5000);
        if (n >= 5000) stuck <= 1'b1;
        cyc(3);
    endtask
    // sda moves only mid-low, never near an scl edge
    task automatic bit_io(input logic v, output logic s);
        cyc(2);
        sda_dn <= ~v;
        cyc(2);
        hi();
        s = sda;
        scl_dn <= 1'b1;
    endtask
    task automatic start_c();
        sda_dn <= 1'b1;
        cyc(4);
        scl_dn <= 1'b1;
    endtask
    task automatic stop_c();
        cyc(2);
        sda_dn <= 1'b1;
        cyc(2);
        hi();
        sda_dn <= 1'b0;
        cyc(4);
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    // ninth clock: ack keeps the slave sending, nack ends it
    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(~ack, s);
    endtask
endmodule

/* File: tb/two_wire_slave_transmitter_test.sv */
// Purpose: self-checking bench for the two-wire slave transmitter
// Assumes: open-drain lines pulled up, master model drives the bus
// Notes: every wait is bounded and ends in the closing report
`timescale 1ns/10ps
module two_wire_slave_transmitter_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic sleep_mode = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rv;
    logic pready, pslverr, er, scl_oe, sda_oe, wake_req;
    logic m_scl, m_sda, stuck, ak;
    logic [7:0] b;
    int miscompares = 0;
    int checked = 0;
    wire scl = ~(scl_oe | m_scl);
    wire sda = ~(sda_oe | m_sda);
    always #4 pclk = ~pclk;
    tws_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_i(scl), .sda_i(sda),
        .sleep_mode(sleep_mode), .scl_o(), .scl_oe(scl_oe), .sda_o(),
        .sda_oe(sda_oe), .wake_req(wake_req));
    tws_master_model M (.pclk(pclk), .scl(scl), .sda(sda),
        .scl_dn(m_scl), .sda_dn(m_sda), .stuck(stuck));
    task automatic print_verdict();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk(pready, 1'b1);
        if (n >= 20) print_verdict();
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wt(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 99) begin
            @(posedge pclk);
            n++;
        end
        chk(s, 1'b1);
        if (n >= 99) print_verdict();
    endtask
    task automatic stat(input logic [7:0] e);
        wt(scl_oe);
        apb(1'b0, tws_pkg::OFS_STAT, 32'h0);
        chk(rv, {24'h0, e});
    endtask
    // one final byte answered nack, then leave with control value c
    task automatic tail(input logic [7:0] d, input logic [7:0] c);
        apb(1'b1, tws_pkg::OFS_DATA, {24'h0, d});
        apb(1'b1, tws_pkg::OFS_CTRL, 32'h84);
        M.recv_byte(1'b0, b);
        chk(b, d);
        stat(8'hc0);
        apb(1'b1, tws_pkg::OFS_CTRL, {24'h0, c});
        M.stop_c();
    endtask
    task automatic addr(input logic [7:0] a, input logic e);
        M.start_c();
        M.send_byte(a, ak);
        chk(ak, e);
    endtask
    task automatic t_regs();
        apb(1'b0, tws_pkg::OFS_CTRL, 32'h0);
        chk(rv, 32'h00);
        apb(1'b0, tws_pkg::OFS_STAT, 32'h0);
        chk(rv, 32'hf8);
        apb(1'b0, tws_pkg::OFS_DATA, 32'h0);
        chk(rv, 32'hff);
        apb(1'b0, tws_pkg::OFS_ADDR, 32'h0);
        chk(rv, 32'h00);
        apb(1'b0, 8'h10, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, tws_pkg::OFS_DATA, 32'h12);
        apb(1'b0, tws_pkg::OFS_CTRL, 32'h0);
        chk(rv, 32'h08);
        apb(1'b0, tws_pkg::OFS_DATA, 32'h0);
        chk(rv, 32'hff);
    endtask
    task automatic t_read();
        apb(1'b1, tws_pkg::OFS_ADDR, 32'ha4);
        apb(1'b1, tws_pkg::OFS_CTRL, 32'h44);
        addr(8'ha5, 1'b1);
        stat(8'ha8);
        apb(1'b1, tws_pkg::OFS_DATA, 32'h3c);
        apb(1'b1, tws_pkg::OFS_CTRL, 32'hc4);
        M.recv_byte(1'b1, b);
        chk(b, 8'h3c);
        stat(8'hb8);
        apb(1'b1, tws_pkg::OFS_DATA, 32'hc5);
        apb(1'b1, tws_pkg::OFS_CTRL, 32'h84);
        M.recv_byte(1'b1, b);
        chk(b, 8'hc5);
        stat(8'hc8);
        apb(1'b1, tws_pkg::OFS_CTRL, 32'hc4);
        M.recv_byte(1'b0, b);
        chk(b, 8'hff);
        M.stop_c();
    endtask
    task automatic t_gcall();
        addr(8'h00, 1'b0);
        M.stop_c();
        apb(1'b1, tws_pkg::OFS_ADDR, 32'ha5);
        addr(8'h00, 1'b1);
        stat(8'h70);
        apb(1'b1, tws_pkg::OFS_CTRL, 32'hc4);
        M.stop_c();
    endtask
    task automatic t_sleep();
        sleep_mode <= 1'b1;
        addr(8'ha5, 1'b1);
        wt(wake_req);
        cyc_hold();
        sleep_mode <= 1'b0;
        stat(8'ha8);
        tail(8'h5a, 8'hc4);
    endtask
    task automatic cyc_hold();
        repeat (50) @(posedge pclk);
        chk(scl_oe, 1'b1);
    endtask
    task automatic t_isolate();
        apb(1'b1, tws_pkg::OFS_CTRL, 32'h04);
        addr(8'ha5, 1'b0);
        M.stop_c();
        apb(1'b1, tws_pkg::OFS_CTRL, 32'h44);
        addr(8'ha5, 1'b1);
        stat(8'ha8);
        apb(1'b1, tws_pkg::OFS_DATA, 32'h81);
        apb(1'b1, tws_pkg::OFS_CTRL, 32'h84);
        M.recv_byte(1'b0, b);
        chk(b, 8'h81);
        stat(8'hc0);
        apb(1'b1, tws_pkg::OFS_CTRL, 32'he4);
        // repeated start while our start is pending: lost to another master
        M.hi();
        addr(8'ha5, 1'b1);
        stat(8'hb0);
        tail(8'h42, 8'he4);
        wt(sda_oe);
        chk(scl, 1'b1);
        repeat (tws_pkg::HD_STA_CYC + 20) @(posedge pclk);
        stat(8'h08);
    endtask
    always @(posedge pclk) begin
        if (stuck === 1'b1) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_read();
        t_gcall();
        t_sleep();
        t_isolate();
        print_verdict();
    end
endmodule
